// File: verilog/lwdt_pkg.sv
// Purpose: Shared constants and types of the low-frequency supervision timer
// Assumes: APB register slave, 32-bit data, one aligned word per register
// Notes:   All offsets, fields, reset values and timing counts live here

package lwdt_pkg;

   // ----------------------------------------------------------------------
   // Clocking
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_HZ     = 25000000;        // System clock rate
   localparam int unsigned LFO_HZ     = 80000;           // Low-frequency oscillator
   localparam int unsigned LFO_DIV    = CLK_HZ / LFO_HZ; // Clocks per oscillator tick
   localparam int unsigned RST_HOLD_NS = 1000;           // Reset request length
   localparam int unsigned RST_HOLD_CYC =
      (RST_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;  // Rounded up, in clocks

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;                   // Decoded address bits
   localparam int unsigned DATA_W = 32;                  // APB data width
   localparam int unsigned CNT_W  = 21;                  // Holds longest interval
   localparam int unsigned HOLD_W = 8;                   // Reset hold counter
   localparam int unsigned SEL_W  = 3;                   // Interval select field

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS  = 8'h00;      // Enable, lock, restart
   localparam logic [ADDR_W-1:0] INTV_OFS  = 8'h04;      // Timeout select
   localparam logic [ADDR_W-1:0] STAT_OFS  = 8'h08;      // Running, locked, reset request active
   localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h0C;      // Live tick count

   // Field positions
   localparam int unsigned CTRL_EN_BIT   = 0;            // 1 = counting
   localparam int unsigned CTRL_LOCK_BIT = 1;            // Write 1 to lock on
   localparam int unsigned CTRL_RST_BIT  = 2;            // Write 1 to restart
   localparam int unsigned STAT_RUN_BIT  = 0;            // Counter running
   localparam int unsigned STAT_LOCK_BIT = 1;            // Lock is set
   localparam int unsigned STAT_FIRE_BIT = 2;            // Reset request active

   // Reset values and interval encoding
   localparam logic [SEL_W-1:0]  SEL_MAX    = 3'h7;      // Longest interval
   localparam logic [4:0]        INTV_SHIFT = 5'h06;     // Ticks = 2^(6 + 2*sel)
   localparam logic [HOLD_W-1:0] HOLD_LAST  = HOLD_W'(RST_HOLD_CYC - 1);

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF  = 3'h1,                                    // Disabled, count idle
      ST_RUN  = 3'h2,                                    // Counting ticks
      ST_FIRE = 3'h4                                     // Driving reset request
   } lwdt_state_t;

   typedef struct packed {
      lwdt_state_t             state;                    // Supervisor state
      logic                    lock;                     // Locked on
      logic [SEL_W-1:0]        sel;                      // Interval select
      logic [CNT_W-1:0]        cnt;                      // Tick counter
      logic [HOLD_W-1:0]       hold;                     // Reset hold count
      logic                    pready;                   // APB ready
      logic                    pslverr;                  // APB error
      logic [DATA_W-1:0]       prdata;                   // APB read data
      logic                    sys_rst;                  // Reset request
      logic                    pin_oe_n;                 // Reset pin drive enable
   } lwdt_regs_t;

endpackage : lwdt_pkg

// File: verilog/lwdt_rst_sync.sv
// Purpose: Releases the asynchronous reset through two flip-flops
// Assumes: Reset is active low
// Notes:   Assertion is immediate, release is aligned to the clock

`timescale 1ns/1ns

module lwdt_rst_sync (
   // Clock and raw reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Synchronised reset
   output logic      rstn_o
);

   typedef struct packed {
      logic [1:0] stage;                                 // Shift chain
   } lwdt_sync_t;

   lwdt_sync_t sync_reg;                                 // Current state
   lwdt_sync_t sync_next;                                // Next state

   // Shift a one in behind the reset
   always_comb begin
      sync_next = '{stage: {sync_reg.stage[0], 1'b1}};
   end

   // Clear on reset, fill after release
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign rstn_o = sync_reg.stage[1];

endmodule : lwdt_rst_sync

// File: verilog/lwdt_tick_gen.sv
// Purpose: Stands in for the low-frequency oscillator as a one-clock tick
// Assumes: DIV is at least two
// Notes:   Tick fires once every DIV clocks, starting after reset

`timescale 1ns/1ns

module lwdt_tick_gen #(
   parameter int unsigned DIV = 312                      // Clocks per tick
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Tick out
   output logic      tick_o
);

   localparam int unsigned W = $clog2(DIV);             // Counter width
   localparam logic [W-1:0] LAST = W'(DIV - 1);         // Final count

   typedef struct packed {
      logic [W-1:0] cnt;                                 // Divider count
      logic         tick;                                // Tick pulse
   } lwdt_tick_t;

   lwdt_tick_t tick_reg;                                 // Current state
   lwdt_tick_t tick_next;                                // Next state

   // Count up and wrap, pulsing at the wrap
   always_comb begin
      tick_next = tick_reg;
      tick_next.tick = (tick_reg.cnt == LAST);
      if (tick_reg.cnt == LAST) begin
         tick_next.cnt = '0;
      end else begin
         tick_next.cnt = tick_reg.cnt + W'(1);
      end
   end

   // Register the divider
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_next;
      end
   end

   assign tick_o = tick_reg.tick;

endmodule : lwdt_tick_gen

// File: verilog/lwdt_top.sv
// Purpose: Supervision timer that resets the microcontroller on overflow
// Assumes: APB master keeps setup and access phases; one system clock
// Notes:   Counts low-frequency oscillator ticks derived from the clock
//
// What this block does
// - Overflow forces the whole controller into reset
// - Comes up enabled at the longest interval
// - Software may disable it or lock it on
// - Lock ignores disable until system reset
// - Lock blocks all settings changes, interval included
// - Overflow reset never drives the reset pin
// - Counts oscillator ticks; interval is programmable
// - Oscillator runs at nominal 80 kHz
//
// Added by the designer: the APB slave port and the placing of the registers.

`timescale 1ns/1ns

module lwdt_top
   import lwdt_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   // APB slave
   input  wire logic                       psel_i,
   input  wire logic                       penable_i,
   input  wire logic                       pwrite_i,
   input  wire logic [lwdt_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [lwdt_pkg::DATA_W-1:0] pwdata_i,
   output logic      [lwdt_pkg::DATA_W-1:0] prdata_o,
   output logic                            pready_o,
   output logic                            pslverr_o,
   // System reset request and reset pin control
   output logic                            sys_reset_o,
   output logic                            rst_pin_oe_n_o
);

   import lwdt_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic             rst_n;                              // Synchronised reset
   logic             tick;                               // Oscillator tick
   lwdt_regs_t       st_reg;                             // All block state
   lwdt_regs_t       st_next;                            // Next state
   logic             setup;                              // APB setup phase
   logic             wr_acc;                             // Write taking effect
   logic [CNT_W-1:0] limit;                              // Ticks per interval
   logic [4:0]       shamt;                              // Interval shift
   logic             restart;                            // Restart requested
   logic             wr_ctrl;                            // Control written
   logic             wr_intv;                            // Interval written
   logic             hit;                                // Counter at limit
   logic             mapped;                             // Address decodes

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------

   // Two-stage release of the external reset
   lwdt_rst_sync u_rst_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .rstn_o (rst_n)
   );

   // ----------------------------------------------------------------------
   // Oscillator tick
   // ----------------------------------------------------------------------

   // One tick per 80 kHz period; the counter sees no system-clock edge
   // as a count, only these ticks
   lwdt_tick_gen #(
      .DIV (LFO_DIV)
   ) u_tick (
      .clk_i  (clk_i),
      .rstn_i (rst_n),
      .tick_o (tick)
   );

   // ----------------------------------------------------------------------
   // Bus phase decode
   // ----------------------------------------------------------------------

   // Setup cycle is psel without penable; the write lands at the edge
   // where the master sees our ready, and at no other
   assign setup  = psel_i & ~penable_i;
   assign wr_acc = psel_i & penable_i & pwrite_i & st_reg.pready;

   // Address decode of the four words
   always_comb begin
      if (paddr_i == CTRL_OFS) begin
         mapped = 1'b1;
      end else if (paddr_i == INTV_OFS) begin
         mapped = 1'b1;
      end else if (paddr_i == STAT_OFS) begin
         mapped = 1'b1;
      end else if (paddr_i == COUNT_OFS) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   // Which register a completing write touches
   assign wr_ctrl = wr_acc & (paddr_i == CTRL_OFS);
   assign wr_intv = wr_acc & (paddr_i == INTV_OFS);

   // A restart is a write of one to the restart bit; software must do
   // this before every overflow while counting
   assign restart = wr_ctrl & pwdata_i[CTRL_RST_BIT];

   // ----------------------------------------------------------------------
   // Interval
   // ----------------------------------------------------------------------

   // Interval length is 2^(6 + 2*select) ticks, select 0 to 7
   assign shamt = INTV_SHIFT + {1'b0, st_reg.sel, 1'b0};
   assign limit = CNT_W'(1) << shamt;

   // Greater-or-equal so a shorter interval set mid-count still trips
   assign hit = (st_reg.cnt >= (limit - CNT_W'(1)));

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------

   // Bus answer, control writes and the counting machine in one place
   always_comb begin
      st_next = st_reg;

      // Reset pin is never driven by this block
      st_next.pin_oe_n = 1'b1;

      // Ready is one cycle, in the first access cycle
      st_next.pready  = setup & ~st_reg.pready;
      st_next.pslverr = 1'b0;

      // Read data and error are prepared in the setup cycle
      if (setup) begin
         st_next.prdata  = '0;
         st_next.pslverr = ~mapped;
         if (paddr_i == CTRL_OFS) begin
            // Enable and lock read back; restart reads zero
            st_next.prdata[CTRL_EN_BIT]   = (st_reg.state != ST_OFF);
            st_next.prdata[CTRL_LOCK_BIT] = st_reg.lock;
         end else if (paddr_i == INTV_OFS) begin
            // Interval select
            st_next.prdata[SEL_W-1:0] = st_reg.sel;
         end else if (paddr_i == STAT_OFS) begin
            // Live state of the supervisor
            st_next.prdata[STAT_RUN_BIT]  = (st_reg.state == ST_RUN);
            st_next.prdata[STAT_LOCK_BIT] = st_reg.lock;
            st_next.prdata[STAT_FIRE_BIT] = (st_reg.state == ST_FIRE);
         end else if (paddr_i == COUNT_OFS) begin
            // Ticks counted so far in this interval
            st_next.prdata[CNT_W-1:0] = st_reg.cnt;
         end else begin
            // Unmapped: zero data with error
            st_next.prdata = '0;
         end
      end

      // Interval change only while unlocked
      if (wr_intv && !st_reg.lock) begin
         st_next.sel = pwdata_i[SEL_W-1:0];
      end

      // Supervisor state machine
      case (st_reg.state)
         ST_OFF: begin
            // Idle; an enable or a lock starts a fresh interval
            st_next.cnt = '0;
            if (wr_ctrl && !st_reg.lock) begin
               if (pwdata_i[CTRL_LOCK_BIT]) begin
                  // Locking also switches it on
                  st_next.lock  = 1'b1;
                  st_next.state = ST_RUN;
               end else if (pwdata_i[CTRL_EN_BIT]) begin
                  st_next.state = ST_RUN;
               end else begin
                  st_next.state = ST_OFF;
               end
            end
         end
         ST_RUN: begin
            if (restart) begin
               // Restart wins over a tick in the same cycle
               st_next.cnt = '0;
            end else if (tick && hit) begin
               // Overflow: request a full system reset
               st_next.cnt     = '0;
               st_next.hold    = HOLD_LAST;
               st_next.sys_rst = 1'b1;
               st_next.state   = ST_FIRE;
            end else if (tick) begin
               st_next.cnt = st_reg.cnt + CNT_W'(1);
            end else begin
               st_next.cnt = st_reg.cnt;
            end
            if (wr_ctrl && pwdata_i[CTRL_LOCK_BIT]) begin
               // Lock sticks until the next system reset
               st_next.lock = 1'b1;
            end
            if (wr_ctrl && !pwdata_i[CTRL_EN_BIT] && !pwdata_i[CTRL_LOCK_BIT]
                && !st_reg.lock) begin
               // Disable honoured only while unlocked
               st_next.state   = ST_OFF;
               st_next.cnt     = '0;
               st_next.sys_rst = 1'b0;
            end
         end
         ST_FIRE: begin
            // Hold the reset request for its full length
            st_next.sys_rst = 1'b1;
            if (st_reg.hold == '0) begin
               st_next.sys_rst = 1'b0;
               st_next.state   = ST_RUN;
            end else begin
               st_next.hold = st_reg.hold - HOLD_W'(1);
            end
            if (wr_ctrl && pwdata_i[CTRL_LOCK_BIT]) begin
               st_next.lock = 1'b1;
            end
         end
         default: begin
            // Recover from an illegal code by restarting enabled
            st_next.state   = ST_RUN;
            st_next.cnt     = '0;
            st_next.sys_rst = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------

   // Any reset brings the supervisor up counting at the longest interval,
   // unlocked, with the reset pin released
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg          <= '0;
         st_reg.state    <= ST_RUN;
         st_reg.sel      <= SEL_MAX;
         st_reg.lock     <= 1'b0;
         st_reg.pin_oe_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, each straight from the state register
   // ----------------------------------------------------------------------

   // Bus answer
   assign prdata_o  = st_reg.prdata;
   assign pready_o  = st_reg.pready;
   assign pslverr_o = st_reg.pslverr;

   // Reset request into the reset controller; the pin stays undriven
   assign sys_reset_o    = st_reg.sys_rst;
   assign rst_pin_oe_n_o = st_reg.pin_oe_n;

endmodule : lwdt_top

// File: tb/lwdt_asserts.sv
// Purpose: Port assertions for the supervision timer
// Assumes: Bench keeps APB setup and access phases
// Notes:   Helper models track lock, enable, interval and quiet time
`timescale 1ns/1ns
module lwdt_asserts
   import lwdt_pkg::*;
(
   // Clock and reset
   input wire logic                        clk_i,
   input wire logic                        rstn_i,
   // APB
   input wire logic                        psel_i,
   input wire logic                        penable_i,
   input wire logic                        pwrite_i,
   input wire logic [lwdt_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [lwdt_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [lwdt_pkg::DATA_W-1:0] prdata_o,
   input wire logic                        pready_o,
   input wire logic                        pslverr_o,
   // Reset request and pin
   input wire logic                        sys_reset_o,
   input wire logic                        rst_pin_oe_n_o
);
   // ----------------------------------------------
   // Helper models
   // ----------------------------------------------
   localparam int MIN_FIRE = 63 * LFO_DIV;   // Shortest run to overflow
   logic              done;                  // Accepted transfer
   logic              wr_ctrl;               // Control write
   logic              wr_intv;               // Interval write that lands
   logic              clr;                   // Count is cleared
   logic              lock_m;                // Lock seen
   logic              en_m;                  // Supervisor on
   logic              intv_wr;               // Interval written
   logic [SEL_W-1:0]  sel_m;                 // Expected interval
   logic [31:0]       quiet;                 // Clocks since count cleared
   logic [31:0]       hi_cnt;                // Reset request length
   assign done    = psel_i && penable_i && pready_o && !pslverr_o;
   assign wr_ctrl = done && pwrite_i && paddr_i == CTRL_OFS;
   assign wr_intv = done && pwrite_i && paddr_i == INTV_OFS && !lock_m;
   // Reset request, restart, a start from off, or an unlocked write that turns it off
   assign clr = sys_reset_o || (wr_ctrl && (pwdata_i[CTRL_RST_BIT] || !en_m ||
                !(lock_m || pwdata_i[CTRL_LOCK_BIT] || pwdata_i[CTRL_EN_BIT])));
   // Follow the settings software has made
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lock_m  <= 1'b0;
         en_m    <= 1'b1;
         intv_wr <= 1'b0;
         sel_m   <= SEL_MAX;
         quiet   <= '0;
         hi_cnt  <= '0;
      end else begin
         if (wr_ctrl) begin
            lock_m <= lock_m || pwdata_i[CTRL_LOCK_BIT];
            en_m   <= lock_m || pwdata_i[CTRL_LOCK_BIT] || pwdata_i[CTRL_EN_BIT];
         end
         if (wr_intv) begin
            intv_wr <= 1'b1;
            sel_m   <= pwdata_i[SEL_W-1:0];
         end
         quiet  <= clr ? '0 : quiet + 32'h1;
         hi_cnt <= sys_reset_o ? hi_cnt + 32'h1 : '0;
      end
   end
   // ----------------------------------------------
   // Properties
   // ----------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Completed read of one address
   sequence s_rd(logic [ADDR_W-1:0] a);
      done && !pwrite_i && paddr_i == a;
   endsequence
   AST_HOLD_LEN: assert property ($fell(sys_reset_o) |-> hi_cnt == RST_HOLD_CYC)
      else $error("reset request length wrong");
   AST_INTV_RESET: assert property (s_rd(INTV_OFS) ##0 !intv_wr |-> prdata_o == 32'(SEL_MAX))
      else $error("interval not longest after reset");
   AST_OFF_STAT: assert property (s_rd(STAT_OFS) ##0 !en_m |-> !prdata_o[STAT_RUN_BIT])
      else $error("disabled supervisor reads as running");
   AST_LOCK_STAT: assert property (s_rd(STAT_OFS) ##0 (lock_m && !$past(sys_reset_o))
      |-> prdata_o[STAT_LOCK_BIT] && prdata_o[STAT_RUN_BIT])
      else $error("locked supervisor not running");
   AST_LOCK_INTV: assert property (s_rd(INTV_OFS) ##0 lock_m |-> prdata_o == 32'(sel_m))
      else $error("interval changed under lock");
   AST_INTV_PROG: assert property (s_rd(INTV_OFS) ##0 !lock_m |-> prdata_o == 32'(sel_m))
      else $error("interval not as programmed");
   AST_PIN_IDLE: assert property (sys_reset_o |-> rst_pin_oe_n_o ##1 rst_pin_oe_n_o)
      else $error("reset pin driven");
   AST_TICK_RATE: assert property (s_rd(COUNT_OFS) |-> prdata_o <= quiet / LFO_DIV + 1)
      else $error("count runs faster than the oscillator");
   AST_FULL_RUN: assert property ($rose(sys_reset_o) |-> quiet >= MIN_FIRE)
      else $error("overflow before a full interval");
endmodule : lwdt_asserts

// File: tb/tb.sv
// Purpose: Self-checking bench for the supervision timer
// Assumes: APB slave answers within a few clocks
// Notes:   Interval 0 keeps each overflow near 20000 clocks
`timescale 1ns/1ns
bind lwdt_top lwdt_asserts i_lwdt_asserts (
   .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .sys_reset_o(sys_reset_o),
   .rst_pin_oe_n_o(rst_pin_oe_n_o)
);
module tb;
   import lwdt_pkg::*;
   // ----------------------------------------------
   // Signals
   // ----------------------------------------------
   localparam int     LIMIT     = 97000;     // Cycle ceiling
   logic              clk_i     = 1'b0;      // System clock
   logic              rstn_i    = 1'b0;      // Reset, active low
   logic              psel_i    = 1'b0;      // APB select
   logic              penable_i = 1'b0;      // APB enable
   logic              pwrite_i  = 1'b0;      // APB direction
   logic [ADDR_W-1:0] paddr_i   = '0;        // APB address
   logic [DATA_W-1:0] pwdata_i  = '0;        // APB write data
   logic [DATA_W-1:0] prdata_o;              // APB read data
   logic              pready_o;              // APB ready
   logic              pslverr_o;             // APB error
   logic              sys_reset_o;           // Reset request
   logic              rst_pin_oe_n_o;        // Pin drive enable
   int                bad_count = 0;         // Mismatches
   int                checked   = 0;         // Comparisons
   int                cyc       = 0;         // Clock count
   int                t0;                    // Start of a timed run
   logic              fired;                 // Reset request seen
   logic [DATA_W-1:0] rd;                    // Last read data
   logic              err;                   // Last error flag

   always #20 clk_i = ~clk_i;

   lwdt_top i_lwdt_top (
      .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .sys_reset_o(sys_reset_o),
      .rst_pin_oe_n_o(rst_pin_oe_n_o)
   );
   // ----------------------------------------------
   // Tasks
   // ----------------------------------------------
   // Verdict and end of run
   task automatic complete_run();
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   // Compare one value
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer; holds the request until ready is sampled
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      check(32'(pready_o), 32'h1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   // Reset pulse and release
   task automatic do_reset();
      rstn_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask : do_reset
   // Wait, noting any reset request
   task automatic idle(input int n);
      fired = 1'b0;
      repeat (n) begin
         @(posedge clk_i);
         if (sys_reset_o !== 1'b0) fired = 1'b1;
      end
   endtask : idle
   // Overflow must come in its window and hold its length
   task automatic expect_fire();
      int hi;
      hi = 0;
      while (sys_reset_o !== 1'b1 && cyc - t0 < 20100) @(posedge clk_i);
      check(32'(cyc - t0 >= 19600 && cyc - t0 < 20100), 32'h1);
      while (sys_reset_o === 1'b1 && hi < 100) begin
         check(32'(rst_pin_oe_n_o), 32'h1);
         @(posedge clk_i);
         hi++;
      end
      check(32'(hi), 32'(RST_HOLD_CYC));
   endtask : expect_fire
   // Cycle ceiling
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         complete_run();
      end
   end
   // ----------------------------------------------
   // Scenarios
   // ----------------------------------------------
   initial begin
      do_reset();
      bus(1'b0, CTRL_OFS, '0);
      check(rd, 32'h1);
      bus(1'b0, INTV_OFS, '0);
      check(rd, 32'h7);
      bus(1'b0, STAT_OFS, '0);
      check(rd, 32'h1);
      bus(1'b1, 8'h10, 32'h7);
      check(32'(err), 32'h1);
      bus(1'b0, 8'h10, '0);
      check(rd, '0);
      // Shortest interval, then restarts
      bus(1'b1, INTV_OFS, '0);
      bus(1'b0, INTV_OFS, '0);
      check(rd, '0);
      bus(1'b1, CTRL_OFS, 32'h5);
      idle(15000);
      bus(1'b0, COUNT_OFS, '0);
      check(32'(rd >= 46 && rd <= 49), 32'h1);
      bus(1'b1, CTRL_OFS, 32'h5);
      t0 = cyc;
      bus(1'b0, COUNT_OFS, '0);
      check(32'(rd <= 1), 32'h1);
      idle(15000);
      check(32'(fired), '0);
      expect_fire();
      // Turned off: no overflow
      bus(1'b1, CTRL_OFS, '0);
      bus(1'b0, STAT_OFS, '0);
      check(rd, '0);
      idle(20300);
      check(32'(fired), '0);
      // Enable alone switches it back on
      bus(1'b1, CTRL_OFS, 32'h1);
      bus(1'b0, CTRL_OFS, '0);
      check(rd, 32'h1);
      // Locked on: settings frozen, overflow still fires
      bus(1'b1, CTRL_OFS, 32'h2);
      t0 = cyc;
      bus(1'b1, CTRL_OFS, '0);
      bus(1'b0, STAT_OFS, '0);
      check(rd, 32'h3);
      bus(1'b1, INTV_OFS, 32'h3);
      bus(1'b0, INTV_OFS, '0);
      check(rd, '0);
      expect_fire();
      // System reset clears the lock
      do_reset();
      bus(1'b0, STAT_OFS, '0);
      check(rd, 32'h1);
      bus(1'b0, INTV_OFS, '0);
      check(rd, 32'h7);
      complete_run();
   end
endmodule : tb
